// file: pkg/csc_pkg.sv
// Constants, timing figures and carrier types for the charger sequence control.
// Assumes a single 125 MHz clock; every analog decision arrives as a comparator level.
package csc_pkg;

    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned DEAD_TIME_NS    = 10_000;
    localparam int unsigned SW_FREQ_HZ      = 1_600_000;
    localparam int unsigned SS_STEP_US      = 1_600;
    localparam int unsigned DET_SINK_MS     = 1_000;
    localparam int unsigned DET_CHG_MS      = 500;
    localparam int unsigned SHORT_HALT_US   = 1_000;
    localparam int unsigned OV_LIMIT_MS     = 30;
    localparam int unsigned BLINK_MS        = 250;
    localparam int unsigned SKIP_DUTY_PCT   = 97;
    localparam int unsigned SS_LEVELS       = 8;
    localparam int unsigned REFRESH_NS      = 200;

    localparam int unsigned DEAD_CYC   = (DEAD_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned PERIOD_CYC = CLK_HZ / SW_FREQ_HZ;
    localparam int unsigned SKIP_CYC   = PERIOD_CYC * SKIP_DUTY_PCT / 100;
    localparam int unsigned REFRESH_CYC = (REFRESH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam longint unsigned SS_STEP_CYC  = longint'(SS_STEP_US) * (CLK_HZ / 1_000_000);
    localparam longint unsigned DET_SINK_CYC = longint'(DET_SINK_MS) * (CLK_HZ / 1000);
    localparam longint unsigned DET_CHG_CYC  = longint'(DET_CHG_MS) * (CLK_HZ / 1000);
    localparam longint unsigned HALT_CYC     = longint'(SHORT_HALT_US) * (CLK_HZ / 1_000_000);
    localparam longint unsigned OV_CYC       = longint'(OV_LIMIT_MS) * (CLK_HZ / 1000);
    localparam longint unsigned BLINK_CYC    = longint'(BLINK_MS) * (CLK_HZ / 1000);

    localparam int unsigned LEVEL_W = 3;
    localparam logic [LEVEL_W-1:0] LEVEL_MAX = 3'h7;
    localparam logic [LEVEL_W-1:0] LEVEL_MIN = 3'h0;

    // Comparator levels from the analog front end, each synchronised in two stages inside csc_sequencer.
    typedef struct packed {
        logic in_window;       // Input qualify sense between under and over limit.
        logic supply_above;    // Supply pin above battery sense by 210 mV.
        logic sys_near_bat;    // System node close to battery voltage.
        logic charge_current_set_low;        // Current-set below 40 mV.
        logic charge_current_set_high;       // Current-set above 120 mV.
        logic bat_below_rechg; // Battery below recharge threshold.
        logic bat_below_low;   // Battery below low threshold.
        logic bat_short;       // Battery below 2 V.
        logic bat_ov;          // Battery above 102 percent of regulation.
        logic therm_ok;        // Thermistor between cold and hot limits.
        logic tj_fold;         // Junction near 120 C.
        logic tj_hot;          // Junction above 150 C.
        logic tj_cool;         // Junction below 130 C.
        logic timer_fault;     // Charge timer expired.
        logic hs_peak;         // High-side current above 10 A.
        logic chg_oc;          // Charge current above 180 percent of setting.
        logic sense_low;       // Charge sense below 5 mV.
        logic boot_low;        // High-side driver supply below 3 V.
        logic sw_short;        // Switch short circuit seen.
        logic duty_high;       // Demanded duty at or above skip level.
    } csc_sense_t;

    typedef struct packed {
        logic                adapter_switch_gate;
        logic                battery_switch_gate;
        logic                hs_on;
        logic                ls_on;
        logic                sink_9m5;
        logic                sink_6m;
        logic                small_charge;
        logic                precharge;
        logic                fold_back;
        logic [LEVEL_W-1:0]  current_level;
    } csc_drive_t;

endpackage

// file: src/csc_pwm_gate.sv
// Cycle-level switch gating for the step-down converter.
// Assumes the sense levels are already synchronised to clk.
`timescale 1ns/100ps
module csc_pwm_gate
    import csc_pkg::*;
#(
    parameter int unsigned PERIOD = PERIOD_CYC
)(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Control.
    input  wire logic run,
    input  wire logic sync_en,
    input  wire logic ov_block,
    input  wire logic peak_oc,
    input  wire logic chg_oc,
    input  wire logic sense_low,
    input  wire logic boot_low,
    input  wire logic duty_high,
    // Switch drive.
    output logic      hs_on,
    output logic      ls_on,
    output logic      cycle_start
);

    logic [7:0] phase_reg;
    logic [7:0] phase_next;
    logic       hs_cut_reg;
    logic       hs_cut_next;
    logic       ls_cut_reg;
    logic       ls_cut_next;
    logic [7:0] refresh_reg;
    logic [7:0] refresh_next;
    logic       skip_reg;
    logic       skip_next;

    ////////////////////////////////////////////////////////////////////////////
    // fixed period counter
    assign cycle_start = (phase_reg == 8'(PERIOD - 1));
    assign phase_next  = cycle_start ? 8'h00 : phase_reg + 8'h01;
    assign skip_next   = cycle_start ? duty_high : skip_reg;
    assign hs_cut_next = cycle_start ? 1'b0 : (hs_cut_reg | peak_oc);
    assign ls_cut_next = cycle_start ? 1'b0 : (ls_cut_reg | sense_low);
    assign refresh_next = (boot_low && refresh_reg == 8'h00) ? 8'(REFRESH_CYC) :
                          (refresh_reg != 8'h00) ? refresh_reg - 8'h01 : 8'h00;

    wire high_phase = (phase_reg < 8'(PERIOD / 2)) && !skip_reg;
    assign hs_on = run && high_phase && !hs_cut_reg && !peak_oc && !chg_oc && !ov_block;
    assign ls_on = (refresh_reg != 8'h00) ||
                   (run && sync_en && !high_phase && !ls_cut_reg && !sense_low);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_reg   <= 8'h00;
            hs_cut_reg  <= 1'b0;
            ls_cut_reg  <= 1'b0;
            refresh_reg <= 8'h00;
            skip_reg    <= 1'b0;
        end
        else
        begin
            phase_reg   <= phase_next;
            hs_cut_reg  <= hs_cut_next;
            ls_cut_reg  <= ls_cut_next;
            refresh_reg <= refresh_next;
            skip_reg    <= skip_next;
        end
    end

    AST_OC_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        chg_oc |-> !hs_on) else $error("High side on during over-current.");
    AST_BOOT_REFRESH: assert property (@(posedge clk) disable iff (!rst_n)
        (boot_low && refresh_reg == 8'h00) |=> ls_on) else $error("No bootstrap refresh.");
    AST_PEAK_CUT: assert property (@(posedge clk) disable iff (!rst_n)
        (peak_oc && !cycle_start) |=> !hs_on) else $error("High side back on after peak.");
    AST_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
        cycle_start |=> !cycle_start [*8]) else $error("Switching period too short.");

endmodule

// file: src/csc_sequencer.sv
// Top of the charger sequence control: power path, detection, soft-start and faults.
// Assumes comparator levels arrive from the analog domain and need synchronising.
`timescale 1ns/100ps
module csc_sequencer
    import csc_pkg::*;
#(
    parameter longint unsigned SS_STEP  = SS_STEP_CYC,
    parameter longint unsigned DET_SINK = DET_SINK_CYC,
    parameter longint unsigned DET_CHG  = DET_CHG_CYC,
    parameter longint unsigned HALT     = HALT_CYC,
    parameter longint unsigned OV_LIM   = OV_CYC,
    parameter longint unsigned BLINK    = BLINK_CYC
)(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Comparator inputs.
    input  wire csc_sense_t sense_in,
    // Drive outputs.
    output csc_drive_t      drive,
    // Status pin, open drain, and sleep indication.
    output logic            status_out,
    output logic            status_oe_n,
    output logic            in_sleep
);

    typedef enum logic [2:0] {PP_SLEEP, PP_BAT_OFF, PP_DEAD, PP_ADAPTER, PP_WAIT_SYS}
        csc_pp_t;
    typedef enum logic [2:0] {DT_SINK, DT_CHARGE, DT_PRESENT, DT_FAULT_HOLD, DT_FAULT_SMALL}
        csc_det_t;

    csc_sense_t meta_reg;
    csc_sense_t s;
    csc_pp_t    pp_reg;
    csc_pp_t    pp_next;
    csc_det_t   det_reg;
    csc_det_t   det_next;
    logic [31:0] tmr_reg;
    logic [31:0] tmr_next;
    logic [31:0] ss_reg;
    logic [31:0] halt_reg;
    logic [31:0] ov_reg;
    logic [31:0] blink_reg;
    logic [LEVEL_W-1:0] level_reg;
    logic       blink_reg_q;
    logic       latch_reg;
    logic       tshut_reg;
    logic       ovdis_reg;
    logic       enable_reg;
    logic       short_reg;
    logic       charging_reg;
    logic       charging_next;

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser on every comparator level.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            s        <= '0;
        end
        else
        begin
            meta_reg <= sense_in;
            s        <= meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power path selection.
    // connect conditions
    wire connect_ok = s.in_window && s.supply_above;
    always_comb
    begin
        pp_next = pp_reg;
        unique case (pp_reg)
            PP_SLEEP:    pp_next = connect_ok ? PP_BAT_OFF : PP_SLEEP;
            PP_BAT_OFF:  pp_next = connect_ok ? PP_DEAD : PP_WAIT_SYS;
            PP_DEAD:     pp_next = !connect_ok ? PP_WAIT_SYS :
                                   (tmr_reg >= 32'(DEAD_CYC - 1)) ? PP_ADAPTER : PP_DEAD;
            PP_ADAPTER:  pp_next = connect_ok ? PP_ADAPTER : PP_WAIT_SYS;
            PP_WAIT_SYS: pp_next = s.sys_near_bat ? PP_SLEEP : PP_WAIT_SYS;
        endcase
    end
    assign tmr_next = (pp_reg == PP_DEAD) ? tmr_reg + 32'h1 : 32'h0;
    assign in_sleep = (pp_reg == PP_SLEEP) || (pp_reg == PP_WAIT_SYS);

    ////////////////////////////////////////////////////////////////////////////
    // Battery detection and timer fault recovery.
    logic [31:0] det_cnt_reg;
    wire det_tick_sink = det_cnt_reg >= 32'(DET_SINK - 1);
    wire det_tick_chg  = det_cnt_reg >= 32'(DET_CHG - 1);
    always_comb
    begin
        det_next = det_reg;
        unique case (det_reg)
            DT_SINK:        det_next = s.bat_below_low ? DT_CHARGE :
                                       det_tick_sink ? DT_PRESENT : DT_SINK;
            DT_CHARGE:      det_next = !det_tick_chg ? DT_CHARGE :
                                       s.bat_below_rechg ? DT_PRESENT : DT_SINK;
            DT_PRESENT:     det_next = s.timer_fault ?
                                       (s.bat_below_rechg ? DT_FAULT_SMALL : DT_FAULT_HOLD) :
                                       (s.bat_below_rechg && !charging_reg && !charging_next) ?
                                       DT_SINK : DT_PRESENT;
            DT_FAULT_HOLD:  det_next = (s.bat_below_rechg || s.charge_current_set_low) ? DT_SINK : DT_FAULT_HOLD;
            DT_FAULT_SMALL: det_next = s.charge_current_set_low ? DT_SINK :
                                       !s.bat_below_rechg ? DT_FAULT_HOLD : DT_FAULT_SMALL;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable, latches and thermal state.
    // current-set hysteresis
    wire enable_next = s.charge_current_set_low ? 1'b0 : (s.charge_current_set_high ? 1'b1 : enable_reg);
    wire tshut_next  = s.tj_hot ? 1'b1 : (s.tj_cool ? 1'b0 : tshut_reg);
    wire latch_next  = s.sw_short ? 1'b1 : (!connect_ok ? 1'b0 : latch_reg);
    wire ov_expired  = ov_reg >= 32'(OV_LIM - 1);
    wire ovdis_next  = (s.bat_ov && ov_expired) ? 1'b1 : (!enable_reg ? 1'b0 : ovdis_reg);

    wire base_ok = (pp_reg == PP_ADAPTER) && enable_reg && !tshut_reg && !latch_reg &&
                   !ovdis_reg && (det_reg == DT_PRESENT);
    wire start_ok   = base_ok && s.therm_ok;
    wire charge_run = start_ok && (charging_reg || s.therm_ok);
    assign charging_next = base_ok && (charging_reg || s.therm_ok);

    wire short_next = s.bat_short && charging_reg;
    wire halting    = short_next && (halt_reg < 32'(HALT));
    wire ss_step    = ss_reg >= 32'(SS_STEP - 1);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pp_reg       <= PP_SLEEP;
            det_reg      <= DT_SINK;
            tmr_reg      <= 32'h0;
            det_cnt_reg  <= 32'h0;
            enable_reg   <= 1'b0;
            tshut_reg    <= 1'b0;
            latch_reg    <= 1'b0;
            ovdis_reg    <= 1'b0;
            charging_reg <= 1'b0;
            short_reg    <= 1'b0;
        end
        else
        begin
            pp_reg       <= pp_next;
            det_reg      <= det_next;
            tmr_reg      <= tmr_next;
            det_cnt_reg  <= (det_next != det_reg) ? 32'h0 : det_cnt_reg + 32'h1;
            enable_reg   <= enable_next;
            tshut_reg    <= tshut_next;
            latch_reg    <= latch_next;
            ovdis_reg    <= ovdis_next;
            charging_reg <= charging_next;
            short_reg    <= short_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ss_reg    <= 32'h0;
            level_reg <= LEVEL_MIN;
            halt_reg  <= 32'h0;
            ov_reg    <= 32'h0;
        end
        else
        begin
            ss_reg    <= (!charge_run || halting || ss_step) ? 32'h0 : ss_reg + 32'h1;
            level_reg <= (!charge_run || halting) ? LEVEL_MIN :
                         (ss_step && level_reg != LEVEL_MAX) ? level_reg + 3'h1 : level_reg;
            halt_reg  <= !short_next ? 32'h0 : (halting ? halt_reg + 32'h1 : halt_reg);
            ov_reg    <= (!s.bat_ov) ? 32'h0 : (ov_expired ? ov_reg : ov_reg + 32'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Converter gating.
    logic hs_int;
    logic ls_int;
    csc_pwm_gate u_gate (
        .clk         (clk),
        .rst_n       (rst_n),
        .run         (charge_run && !halting),
        .sync_en     (!short_reg),
        .ov_block    (s.bat_ov),
        .peak_oc     (s.hs_peak),
        .chg_oc      (s.chg_oc),
        .sense_low   (s.sense_low),
        .boot_low    (s.boot_low),
        .duty_high   (s.duty_high),
        .hs_on       (hs_int),
        .ls_on       (ls_int),
        .cycle_start ()
    );

    ////////////////////////////////////////////////////////////////////////////
    // Status blink and outputs.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blink_reg   <= 32'h0;
            blink_reg_q <= 1'b0;
        end
        else
        begin
            blink_reg   <= (blink_reg >= 32'(BLINK - 1)) ? 32'h0 : blink_reg + 32'h1;
            blink_reg_q <= (blink_reg >= 32'(BLINK - 1)) ? !blink_reg_q : blink_reg_q;
        end
    end

    wire blink_case = latch_reg || (base_ok && !s.therm_ok) || s.bat_ov || ovdis_reg ||
                      det_reg == DT_FAULT_HOLD || det_reg == DT_FAULT_SMALL ||
                      (!in_sleep && det_reg == DT_CHARGE) || (in_sleep == 1'b0 && !s.in_window);
    wire stat_on = charge_run ? 1'b1 : (blink_case && !in_sleep ? blink_reg_q : 1'b0);
    assign status_out  = 1'b0;
    assign status_oe_n = !stat_on;

    always_comb
    begin
        drive = '0;
        drive.adapter_switch_gate = (pp_reg == PP_ADAPTER);
        drive.battery_switch_gate = (pp_reg == PP_SLEEP);
        drive.hs_on        = hs_int;
        drive.ls_on        = ls_int;
        drive.sink_9m5     = (det_reg == DT_SINK);
        drive.sink_6m      = s.bat_ov;
        drive.small_charge = (det_reg == DT_CHARGE) || (det_reg == DT_FAULT_SMALL);
        drive.precharge    = short_reg;
        drive.fold_back    = s.tj_fold;
        drive.current_level = level_reg;
    end

    AST_DEAD_TIME: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(pp_reg == PP_ADAPTER) |-> $past(pp_reg == PP_DEAD))
        else $error("Adapter switch on without dead time.");
    AST_NO_OVERLAP: assert property (@(posedge clk) disable iff (!rst_n)
        !(drive.adapter_switch_gate && drive.battery_switch_gate))
        else $error("Both path switches on.");
    AST_LOSS: assert property (@(posedge clk) disable iff (!rst_n)
        (pp_reg == PP_ADAPTER && !connect_ok) |=> !drive.adapter_switch_gate)
        else $error("Adapter switch stayed on.");
    AST_OV_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
        s.bat_ov |-> !drive.hs_on) else $error("High side on in over-voltage.");
    AST_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
        (latch_reg && connect_ok && pp_reg == PP_ADAPTER) |=> (!charge_run && latch_reg))
        else $error("Short latch lost.");
    AST_SINK: assert property (@(posedge clk) disable iff (!rst_n)
        (det_reg == DT_SINK && !s.bat_below_low && det_tick_sink) |=> det_reg == DT_PRESENT)
        else $error("Detection did not conclude present.");
    AST_CHARGE_CURRENT_SET: assert property (@(posedge clk) disable iff (!rst_n)
        s.charge_current_set_low |=> !enable_reg) else $error("Charge stayed enabled.");
    AST_TSHUT: assert property (@(posedge clk) disable iff (!rst_n)
        tshut_reg |-> !charge_run) else $error("Charging during thermal shutdown.");

endmodule

// file: testbench/csc_load_model.sv
// Far-side model: adapter qualification, system node decay and battery node.
// Assumes the bench changes plug, sag and bat_absent at the falling edge.
`timescale 1ns/100ps
module csc_load_model
    import csc_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Bench controls and device drive.
    input  wire logic       plug,
    input  wire logic       sag,
    input  wire logic       bat_absent,
    input  wire csc_drive_t drive,
    // Sense levels.
    output logic            in_window,
    output logic            supply_above,
    output logic            sys_near_bat,
    output logic            bat_below_low
);
    logic [3:0] fall_cnt;
    logic [3:0] sink_cnt;
    assign in_window     = plug;
    assign supply_above  = plug && !sag;
    assign sys_near_bat  = (fall_cnt == 4'h8);
    assign bat_below_low = bat_absent && (sink_cnt == 4'h4);
    always @(negedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fall_cnt <= 4'h8;
            sink_cnt <= 4'h0;
        end
        else
        begin
            fall_cnt <= drive.adapter_switch_gate ? 4'h0 : fall_cnt + {3'h0, fall_cnt != 4'h8};
            sink_cnt <= drive.sink_9m5 ? sink_cnt + {3'h0, sink_cnt != 4'h4} : 4'h0;
        end
    end
endmodule

// file: testbench/csc_sequencer_tb_top.sv
// Self-checking bench for the charger sequence control.
// Assumes the shortened counts SS_STEP 20, DET_SINK 50, OV_LIM 40, BLINK 8.
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module csc_sequencer_tb_top
    import csc_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       plug = 1'b0;
    logic       sag = 1'b0;
    logic       bat_gone = 1'b0;
    int         errors = 0;
    int         n_tests = 0;
    int         cyc = 0;
    int         t0;
    int         hs_k;
    int         st_k;
    int         ls_k;
    csc_sense_t s_tb = '0;
    csc_sense_t s_dut;
    csc_drive_t drive;
    logic       status_out;
    logic       status_oe_n;
    logic       in_sleep;
    logic       win;
    logic       sup;
    logic       near;
    logic       low;
    always #4 clk = ~clk;
    always_comb
    begin
        s_dut = s_tb;
        s_dut.in_window = win;
        s_dut.supply_above = sup;
        s_dut.sys_near_bat = near;
        s_dut.bat_below_low = low;
    end
    csc_sequencer #(.SS_STEP(20), .DET_SINK(50), .DET_CHG(30), .HALT(10), .OV_LIM(40),
        .BLINK(8)) dut (.clk(clk), .rst_n(rst_n), .sense_in(s_dut), .drive(drive),
        .status_out(status_out), .status_oe_n(status_oe_n), .in_sleep(in_sleep));
    csc_load_model u_far (.clk(clk), .rst_n(rst_n), .plug(plug), .sag(sag),
        .bat_absent(bat_gone), .drive(drive), .in_window(win), .supply_above(sup),
        .sys_near_bat(near), .bat_below_low(low));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            wrap_up();
        end
    end
    // Counts high cycles of hs_on and ls_on and edges of the status pin over n cycles.
    task automatic sample(input int n);
        logic prev;
        hs_k = 0;
        st_k = 0;
        ls_k = 0;
        prev = status_oe_n;
        repeat (n)
        begin
            @(negedge clk);
            hs_k += (drive.hs_on === 1'b1);
            ls_k += (drive.ls_on === 1'b1);
            st_k += (status_oe_n !== prev);
            prev = status_oe_n;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_power_up();
        `CHK(drive.battery_switch_gate, 1'b1)
        `CHK(drive.adapter_switch_gate, 1'b0)
        `CHK(status_oe_n, 1'b1)
        `CHK(status_out, 1'b0)
        repeat (6) @(negedge clk);
        `CHK(drive.sink_9m5, 1'b1)
        plug = 1'b1;
        sag = 1'b1;
        repeat (70) @(negedge clk);
        `CHK(drive.adapter_switch_gate, 1'b0)
        `CHK(drive.sink_9m5, 1'b0)
        $display("done power up and detection");
    endtask
    task automatic t_connect();
        sag = 1'b0;
        for (int i = 0; i < 20 && drive.battery_switch_gate !== 1'b0; i++) @(negedge clk);
        `CHK(drive.adapter_switch_gate, 1'b0)
        t0 = cyc;
        for (int i = 0; i < 2000 && drive.adapter_switch_gate !== 1'b1; i++) @(negedge clk);
        `CHK(cyc - t0 >= DEAD_CYC && cyc - t0 <= DEAD_CYC + 3, 1'b1)
        `CHK(drive.battery_switch_gate, 1'b0)
        $display("done connect");
    endtask
    task automatic t_soft_start();
        for (int i = 0; i < 300 && drive.current_level !== 3'h1; i++) @(negedge clk);
        t0 = cyc;
        for (int i = 0; i < 300 && drive.current_level !== 3'h7; i++) @(negedge clk);
        `CHK(cyc - t0, 6 * 20)
        sample(2 * PERIOD_CYC);
        `CHK(hs_k > 0, 1'b1)
        `CHK(status_oe_n, 1'b0)
        $display("done soft start");
    endtask
    task automatic t_thermistor();
        s_tb.therm_ok = 1'b0;
        repeat (4) @(negedge clk);
        sample(200);
        `CHK(hs_k, 0)
        `CHK(st_k >= 2, 1'b1)
        s_tb.therm_ok = 1'b1;
        repeat (4) @(negedge clk);
        sample(200);
        `CHK(hs_k > 0, 1'b1)
        $display("done thermistor");
    endtask
    task automatic t_over_voltage();
        s_tb.bat_ov = 1'b1;
        repeat (PERIOD_CYC + 3) @(negedge clk);
        `CHK(drive.sink_6m, 1'b1)
        sample(40);
        `CHK(hs_k, 0)
        s_tb.bat_ov = 1'b0;
        sample(300);
        `CHK(hs_k, 0)
        s_tb.charge_current_set_high = 1'b0;
        s_tb.charge_current_set_low = 1'b1;
        sample(20);
        s_tb.charge_current_set_high = 1'b1;
        s_tb.charge_current_set_low = 1'b0;
        sample(400);
        `CHK(hs_k > 0, 1'b1)
        $display("done over voltage");
    endtask
    task automatic t_short_latch();
        s_tb.sw_short = 1'b1;
        repeat (5) @(negedge clk);
        s_tb.sw_short = 1'b0;
        sample(200);
        `CHK(hs_k, 0)
        `CHK(st_k >= 2, 1'b1)
        `CHK(drive.adapter_switch_gate, 1'b1)
        plug = 1'b0;
        repeat (5) @(negedge clk);
        `CHK(drive.adapter_switch_gate, 1'b0)
        `CHK(drive.battery_switch_gate, 1'b0)
        repeat (20) @(negedge clk);
        `CHK(drive.battery_switch_gate, 1'b1)
        `CHK(in_sleep, 1'b1)
        $display("done short latch and removal");
    endtask
    task automatic t_converter();
        s_tb.hs_peak = 1'b1;
        repeat (3) @(negedge clk);
        sample(PERIOD_CYC);
        `CHK(hs_k, 0)
        s_tb.hs_peak = 1'b0;
        s_tb.chg_oc = 1'b1;
        repeat (3) @(negedge clk);
        sample(PERIOD_CYC);
        `CHK(hs_k, 0)
        s_tb.chg_oc = 1'b0;
        s_tb.duty_high = 1'b1;
        repeat (PERIOD_CYC + 3) @(negedge clk);
        sample(PERIOD_CYC);
        `CHK(hs_k, 0)
        s_tb.duty_high = 1'b0;
        s_tb.sense_low = 1'b1;
        s_tb.boot_low = 1'b1;
        repeat (3) @(negedge clk);
        sample(PERIOD_CYC);
        `CHK(ls_k > 0, 1'b1)
        s_tb.boot_low = 1'b0;
        repeat (30) @(negedge clk);
        sample(PERIOD_CYC);
        `CHK(ls_k, 0)
        `CHK(hs_k > 0, 1'b1)
        s_tb.sense_low = 1'b0;
        s_tb.tj_fold = 1'b1;
        s_tb.tj_hot = 1'b1;
        repeat (3) @(negedge clk);
        `CHK(drive.fold_back, 1'b1)
        s_tb.tj_hot = 1'b0;
        sample(PERIOD_CYC);
        `CHK(hs_k, 0)
        s_tb.tj_cool = 1'b1;
        repeat (3) @(negedge clk);
        sample(PERIOD_CYC);
        `CHK(hs_k > 0, 1'b1)
        `CHK(ls_k > 0, 1'b1)
        s_tb.tj_fold = 1'b0;
        s_tb.tj_cool = 1'b0;
        s_tb.bat_short = 1'b1;
        repeat (4) @(negedge clk);
        `CHK(drive.current_level, 3'h0)
        repeat (20) @(negedge clk);
        `CHK(drive.precharge, 1'b1)
        sample(PERIOD_CYC);
        `CHK(ls_k, 0)
        `CHK(hs_k > 0, 1'b1)
        s_tb.bat_short = 1'b0;
        $display("done converter protections");
    endtask
    task automatic t_timer_fault();
        s_tb.timer_fault = 1'b1;
        repeat (4) @(negedge clk);
        s_tb.timer_fault = 1'b0;
        sample(PERIOD_CYC);
        `CHK(hs_k, 0)
        `CHK(st_k >= 2, 1'b1)
        `CHK(drive.sink_9m5, 1'b0)
        s_tb.bat_below_rechg = 1'b1;
        repeat (4) @(negedge clk);
        `CHK(drive.sink_9m5, 1'b1)
        repeat (60) @(negedge clk);
        `CHK(status_oe_n, 1'b0)
        s_tb.timer_fault = 1'b1;
        repeat (4) @(negedge clk);
        s_tb.timer_fault = 1'b0;
        `CHK(drive.small_charge, 1'b1)
        s_tb.bat_below_rechg = 1'b0;
        repeat (4) @(negedge clk);
        `CHK(drive.small_charge, 1'b0)
        `CHK(drive.sink_9m5, 1'b0)
        s_tb.charge_current_set_high = 1'b0;
        s_tb.charge_current_set_low = 1'b1;
        bat_gone = 1'b1;
        repeat (4) @(negedge clk);
        `CHK(drive.sink_9m5, 1'b1)
        s_tb.charge_current_set_high = 1'b1;
        s_tb.charge_current_set_low = 1'b0;
        repeat (8) @(negedge clk);
        `CHK(drive.small_charge, 1'b1)
        repeat (30) @(negedge clk);
        `CHK(drive.sink_9m5, 1'b1)
        bat_gone = 1'b0;
        repeat (60) @(negedge clk);
        `CHK(drive.sink_9m5, 1'b0)
        $display("done timer fault and detection");
    endtask
    initial
    begin
        s_tb.charge_current_set_high = 1'b1;
        s_tb.therm_ok = 1'b1;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_power_up();
        t_connect();
        t_soft_start();
        t_converter();
        t_thermistor();
        t_over_voltage();
        t_timer_fault();
        t_short_latch();
        wrap_up();
    end
endmodule
